// ==== src/ercnt_pkg.sv ====
// package for the receive error counter bank: offsets, widths, carriers
// assumes a byte-wide register read port local to one channel page
package ercnt_pkg;
  localparam int ERCNT_AW = 12;
  localparam int ERCNT_DW = 8;
  localparam int ERCNT_CW = 16;
  // register offsets within the channel page
  localparam logic [11:0] OFS_LVC_HIGH = 12'h900;
  localparam logic [11:0] OFS_LVC_LOW = 12'h901;
  localparam logic [11:0] OFS_FAE_HIGH = 12'h902;
  localparam logic [11:0] OFS_FAE_LOW = 12'h903;
  localparam logic [11:0] OFS_SEF = 12'h904;
  localparam logic [11:0] OFS_SYNC_HIGH = 12'h905;
  localparam logic [11:0] OFS_SYNC_LOW = 12'h906;
  // values after reset and on an unmapped read
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  // index of each 16-bit counter in the generate loop
  localparam int IDX_LVC = 0;
  localparam int IDX_FAE = 1;
  localparam int IDX_SYNC = 2;
  localparam int N_WIDE = 3;

  typedef struct packed {
    logic lcv;      // line code violation strobe
    logic fas_chk;  // a frame alignment word was checked
    logic fas_err;  // that word was in error
    logic crc_err;  // crc-4 bit error strobe
    logic lof;      // loss-of-frame level
  } ercnt_evt_type;

  typedef struct packed {
    logic en;
    logic [11:0] addr;
  } ercnt_rd_type;
endpackage

// ==== src/ercnt_wide_counter.sv ====
// one 16-bit clear-on-read counter split in an upper and a lower byte
// assumes reads are single-cycle strobes, upper byte read first
`timescale 1ns/1ns
`default_nettype none
module ercnt_wide_counter #(
  parameter int CW = 16
) (
  input wire logic clk,              // system clock
  input wire logic nrst,             // async reset, active low
  input wire logic evt,              // one-cycle error event
  input wire logic rd_hi,            // upper byte read strobe
  input wire logic rd_lo,            // lower byte read strobe
  output logic [7:0] rd_byte,        // byte returned for this read
  output logic [CW-1:0] count        // live count
);
  import ercnt_pkg::*;

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [7:0] hold_r;
  logic [7:0] hold_nxt;
  logic armed_r;
  logic armed_nxt;

  // ***************************************************
  // next state
  // ***************************************************
  always_comb begin
    cnt_nxt = cnt_r;
    hold_nxt = hold_r;
    armed_nxt = armed_r;
    rd_byte = BYTE_RESET;
    if (rd_hi) begin
      // lower byte moves to the snapshot and the count clears; a same-cycle event survives
      rd_byte = cnt_r[CW-1:8];
      hold_nxt = cnt_r[7:0];
      armed_nxt = 1'b1;
      cnt_nxt = {{(CW-1){1'b0}}, evt};
    end else if (rd_lo) begin
      if (armed_r) begin
        rd_byte = hold_r;
        hold_nxt = BYTE_RESET;
        armed_nxt = 1'b0;
        cnt_nxt = cnt_r + {{(CW-1){1'b0}}, evt};
      end else begin
        // lone lower read clears only what it returned
        rd_byte = cnt_r[7:0];
        cnt_nxt = {cnt_r[CW-1:8], 8'h00} + {{(CW-1){1'b0}}, evt};
      end
    end else if (evt && cnt_r != {CW{1'b1}}) begin
      // saturates rather than wrapping so a long gap reads as maximum
      cnt_nxt = cnt_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      hold_r <= BYTE_RESET;
      armed_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      hold_r <= hold_nxt;
      armed_r <= armed_nxt;
    end
  end

  assign count = cnt_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  hi_read_clear_a: assert property (rd_hi |=> cnt_r == CW'($past(evt)))
    else $error("counter not cleared by upper byte read");
  pair_snapshot_a: assert property (
    rd_hi ##1 rd_lo |-> rd_byte == $past(cnt_r[7:0]))
    else $error("lower byte differs from snapshot");
endmodule
`default_nettype wire

// ==== src/ercnt_bank.sv ====
// receive error counter bank of one framer channel
// assumes framer strobes and host reads are synchronous to clk
`timescale 1ns/1ns
`default_nettype none
// Function
// - line code violations are counted to 16 bits over two byte registers.
// - framing alignment errors are counted to 16 bits over two byte registers.
// - crc-4 bit errors are counted to 16 bits over two byte registers.
// - severely errored frames are counted to 8 bits in one register.
// - two errored alignment words in a row without loss of frame add one.
// - each register returns counts since its last read and clears on read.
// - reading the upper byte clears a wide counter; the lower read then returns the snapshot.
// - the line code upper byte holds bits 15..8 and clears on read.
module ercnt_bank (
  input wire logic clk,                       // 10 MHz system clock
  input wire logic nrst,                      // async reset, active low
  input wire ercnt_pkg::ercnt_evt_type evt,   // framer error strobes
  input wire ercnt_pkg::ercnt_rd_type rd,     // register read request
  output logic [7:0] rd_data_r,               // read data, next cycle
  output logic rd_valid_r                     // read data valid pulse
);
  import ercnt_pkg::*;

  logic [N_WIDE-1:0] wide_evt;
  logic [N_WIDE-1:0] wide_rd_hi;
  logic [N_WIDE-1:0] wide_rd_lo;
  logic [7:0] wide_byte [N_WIDE];
  logic [ERCNT_CW-1:0] wide_cnt [N_WIDE];
  logic [11:0] hi_ofs [N_WIDE];
  logic [11:0] lo_ofs [N_WIDE];
  logic rd_sef;
  logic sef_evt;
  logic prev_err_r;
  logic prev_err_nxt;
  logic [7:0] sef_cnt_r;
  logic [7:0] sef_cnt_nxt;
  logic [7:0] rd_data_nxt;
  logic mapped;
  logic pair_open_r;
  logic pair_open_nxt;

  assign hi_ofs[IDX_LVC] = OFS_LVC_HIGH;
  assign lo_ofs[IDX_LVC] = OFS_LVC_LOW;
  assign hi_ofs[IDX_FAE] = OFS_FAE_HIGH;
  assign lo_ofs[IDX_FAE] = OFS_FAE_LOW;
  assign hi_ofs[IDX_SYNC] = OFS_SYNC_HIGH;
  assign lo_ofs[IDX_SYNC] = OFS_SYNC_LOW;
  assign wide_evt[IDX_LVC] = evt.lcv;
  assign wide_evt[IDX_FAE] = evt.fas_chk & evt.fas_err;
  assign wide_evt[IDX_SYNC] = evt.crc_err;

  // ***************************************************
  // 16-bit counters
  // ***************************************************
  for (genvar i = 0; i < N_WIDE; i++) begin : g_wide
    assign wide_rd_hi[i] = rd.en && rd.addr == hi_ofs[i];
    assign wide_rd_lo[i] = rd.en && rd.addr == lo_ofs[i];
    ercnt_wide_counter #(
      .CW(ERCNT_CW)
    ) u_cnt (
      .clk(clk),
      .nrst(nrst),
      .evt(wide_evt[i]),
      .rd_hi(wide_rd_hi[i]),
      .rd_lo(wide_rd_lo[i]),
      .rd_byte(wide_byte[i]),
      .count(wide_cnt[i])
    );
  end

  // ***************************************************
  // severely errored frame detection and count
  // ***************************************************
  assign rd_sef = rd.en && rd.addr == OFS_SEF;
  // pairs do not overlap: a third errored word starts a new pair
  assign sef_evt = evt.fas_chk && evt.fas_err && prev_err_r && !evt.lof;

  always_comb begin
    prev_err_nxt = prev_err_r;
    if (evt.lof) begin
      prev_err_nxt = 1'b0;
    end else if (evt.fas_chk) begin
      prev_err_nxt = evt.fas_err && !prev_err_r;
    end
    sef_cnt_nxt = sef_cnt_r;
    if (rd_sef) begin
      // an event in the read cycle lands in the fresh count
      sef_cnt_nxt = {7'h00, sef_evt};
    end else if (sef_evt && sef_cnt_r != 8'hFF) begin
      sef_cnt_nxt = sef_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_err_r <= 1'b0;
      sef_cnt_r <= BYTE_RESET;
    end else begin
      prev_err_r <= prev_err_nxt;
      sef_cnt_r <= sef_cnt_nxt;
    end
  end

  // ***************************************************
  // read port
  // ***************************************************
  always_comb begin
    rd_data_nxt = UNMAPPED_DATA;
    mapped = rd_sef;
    if (rd_sef) begin
      rd_data_nxt = sef_cnt_r;
    end
    for (int i = 0; i < N_WIDE; i++) begin
      if (wide_rd_hi[i] || wide_rd_lo[i]) begin
        rd_data_nxt = wide_byte[i];
        mapped = 1'b1;
      end
    end
    if (!rd.en) begin
      rd_data_nxt = rd_data_r;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_r <= BYTE_RESET;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd.en;
    end
  end

  // ***************************************************
  // assertion helper: reference for an open errored pair
  // ***************************************************
  // opened by a first errored word, shut by any later check or lof;
  // no cycle bound, so a long gap between words is still covered
  always_comb begin
    pair_open_nxt = pair_open_r;
    if (evt.fas_chk && evt.fas_err && !evt.lof && !prev_err_r) begin
      pair_open_nxt = 1'b1;
    end else if (evt.fas_chk || evt.lof) begin
      pair_open_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pair_open_r <= 1'b0;
    end else begin
      pair_open_r <= pair_open_nxt;
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  read_valid_a: assert property (rd.en |=> rd_valid_r)
    else $error("read not answered next cycle");
  lvc_high_a: assert property (wide_rd_hi[IDX_LVC] |=>
    rd_data_r == $past(wide_cnt[IDX_LVC][15:8]))
    else $error("line code upper byte wrong");
  fae_pair_a: assert property (
    wide_rd_hi[IDX_FAE] ##1 wide_rd_lo[IDX_FAE] |=>
    rd_data_r == $past(wide_cnt[IDX_FAE][7:0], 2))
    else $error("framing error pair read wrong");
  sync_clear_a: assert property (wide_rd_hi[IDX_SYNC] |=>
    wide_cnt[IDX_SYNC] == {15'h0000, $past(wide_evt[IDX_SYNC])})
    else $error("sync counter not cleared");
  sef_lof_a: assert property (evt.lof |-> !sef_evt)
    else $error("severe frame counted under loss of frame");
  sef_pair_a: assert property (
    pair_open_r && evt.fas_chk && evt.fas_err && !evt.lof |-> sef_evt)
    else $error("second errored word not counted");
  sef_open_a: assert property (pair_open_r |-> prev_err_r)
    else $error("pending errored word lost");
  sef_break_a: assert property (evt.fas_chk && !evt.fas_err |=> !prev_err_r)
    else $error("good alignment word did not break pair");
  sef_sat_a: assert property (sef_cnt_r == 8'hFF && !rd_sef |=>
    sef_cnt_r == 8'hFF)
    else $error("severe frame count left saturation");
  sef_inc_a: assert property (
    sef_evt && !rd_sef && sef_cnt_r != 8'hFF |=>
    sef_cnt_r == $past(sef_cnt_r) + 8'h01)
    else $error("severe frame count not incremented");
  sef_read_a: assert property (rd_sef |=>
    rd_data_r == $past(sef_cnt_r) && sef_cnt_r == {7'h00, $past(sef_evt)})
    else $error("severe frame read or clear wrong");
  unmapped_a: assert property (rd.en && !mapped |=> rd_data_r == 8'h00)
    else $error("unmapped read not zero");
  read_once_a: assert property (!rd.en |=> !rd_valid_r)
    else $error("read valid without a read");
  data_hold_a: assert property (!rd.en |=> $stable(rd_data_r))
    else $error("read data moved without a read");
  // the wide counters: pair reads, clears and plain counting
  lvc_pair_a: assert property (
    wide_rd_hi[IDX_LVC] ##1 wide_rd_lo[IDX_LVC] |=>
    rd_data_r == $past(wide_cnt[IDX_LVC][7:0], 2))
    else $error("line code pair read wrong");
  sync_pair_a: assert property (
    wide_rd_hi[IDX_SYNC] ##1 wide_rd_lo[IDX_SYNC] |=>
    rd_data_r == $past(wide_cnt[IDX_SYNC][7:0], 2))
    else $error("sync pair read wrong");
  fae_clear_a: assert property (wide_rd_hi[IDX_FAE] |=>
    wide_cnt[IDX_FAE] == {15'h0, $past(wide_evt[IDX_FAE])})
    else $error("framing counter not cleared");
  fae_count_a: assert property (
    wide_evt[IDX_FAE] && !wide_rd_hi[IDX_FAE] && !wide_rd_lo[IDX_FAE] &&
    wide_cnt[IDX_FAE] != 16'hFFFF |=>
    wide_cnt[IDX_FAE] == $past(wide_cnt[IDX_FAE]) + 16'h0001)
    else $error("framing error not counted");
  lvc_count_a: assert property (
    wide_evt[IDX_LVC] && !wide_rd_hi[IDX_LVC] && !wide_rd_lo[IDX_LVC] &&
    wide_cnt[IDX_LVC] != 16'hFFFF |=>
    wide_cnt[IDX_LVC] == $past(wide_cnt[IDX_LVC]) + 16'h0001)
    else $error("line code violation not counted");
  sync_count_a: assert property (
    wide_evt[IDX_SYNC] && !wide_rd_hi[IDX_SYNC] && !wide_rd_lo[IDX_SYNC] &&
    wide_cnt[IDX_SYNC] != 16'hFFFF |=>
    wide_cnt[IDX_SYNC] == $past(wide_cnt[IDX_SYNC]) + 16'h0001)
    else $error("sync bit error not counted");

  pair_read_c: cover property (wide_rd_hi[IDX_LVC] ##1 wide_rd_lo[IDX_LVC]);
  sef_count_c: cover property (sef_evt);
  read_event_c: cover property (wide_rd_hi[IDX_FAE] && wide_evt[IDX_FAE]);
  sef_read_c: cover property (rd_sef && sef_cnt_r != 8'h00);
  lof_break_c: cover property (prev_err_r && evt.lof);
endmodule
`default_nettype wire

// ==== tb/ercnt_framer_model.sv ====
// framer-side stand-in that drives one-cycle error strobes on request
// assumes the bench calls strobe; strobes change at the falling edge
`timescale 1ns/1ns
`default_nettype none
module ercnt_framer_model (
  input wire logic clk,                     // system clock
  output var ercnt_pkg::ercnt_evt_type evt  // error strobes to the bank
);
  import ercnt_pkg::*;
  initial evt = '0;
  // ***************************************
  // strobe driver
  // ***************************************
  // an idle cycle follows each strobe: a framer never reports one
  // alignment word twice, and lof drops with it
  task automatic strobe(input ercnt_evt_type v, input int n);
    repeat (n) begin
      @(negedge clk);
      evt = v;
      @(negedge clk);
      evt = '0;
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the receive error counter bank
// assumes the framer model drives evt and reads take one cycle
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ercnt_pkg::*;
  localparam ercnt_evt_type E_LCV = 5'h10;
  localparam ercnt_evt_type E_FE = 5'h0C;
  localparam ercnt_evt_type E_FG = 5'h08;
  localparam ercnt_evt_type E_FEL = 5'h0D;
  localparam ercnt_evt_type E_CRC = 5'h02;
  logic clk;
  logic nrst;
  ercnt_evt_type evt;
  ercnt_rd_type rd;
  logic [7:0] rd_data_r;
  logic rd_valid_r;
  int err_count;
  int checks_done;
  ercnt_bank ercnt_bank_i (
    .clk(clk), .nrst(nrst), .evt(evt), .rd(rd),
    .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r));
  ercnt_framer_model ercnt_framer_model_i (.clk(clk), .evt(evt));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ***************************************
  // shared tasks
  // ***************************************
  task automatic final_report;
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // answer lands one edge after the take, looked at on the next fall
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd.en = 1'b1;
    rd.addr = a;
    @(negedge clk);
    rd.en = 1'b0;
    chk("rd_valid_r", 8'h01, {7'h00, rd_valid_r});
    chk($sformatf("reg %h", a), exp, rd_data_r);
  endtask
  task automatic rd16(input logic [11:0] hi, input logic [15:0] exp);
    rd_chk(hi, exp[15:8]);
    rd_chk(hi + 12'h001, exp[7:0]);
  endtask
  // ***************************************
  // scenarios
  // ***************************************
  task automatic t_reset;
    for (logic [11:0] a = OFS_LVC_HIGH; a <= OFS_SYNC_LOW; a++)
      rd_chk(a, BYTE_RESET);
    rd_chk(12'h90F, UNMAPPED_DATA);
  endtask
  task automatic t_lcv;
    ercnt_framer_model_i.strobe(E_LCV, 300);
    fork
      rd_chk(OFS_LVC_HIGH, 8'h01);
      ercnt_framer_model_i.strobe(E_LCV, 1);
    join
    rd_chk(OFS_LVC_LOW, 8'h2C);
    rd16(OFS_LVC_HIGH, 16'h0001);
    rd16(OFS_LVC_HIGH, 16'h0000);
  endtask
  task automatic t_fae_crc;
    ercnt_framer_model_i.strobe(E_FEL, 3);
    ercnt_framer_model_i.strobe(E_CRC, 5);
    rd16(OFS_FAE_HIGH, 16'h0003);
    rd16(OFS_SYNC_HIGH, 16'h0005);
    ercnt_framer_model_i.strobe(E_CRC, 2);
    rd_chk(OFS_SYNC_LOW, 8'h02);
    rd16(OFS_SYNC_HIGH, 16'h0000);
    rd_chk(OFS_SEF, 8'h00);
  endtask
  // pairs do not overlap; a good word or lof breaks a pending pair
  task automatic t_sef;
    ercnt_evt_type seq [9];
    seq = '{E_FE, E_FE, E_FE, E_FG, E_FE, E_FEL, E_FG, E_FE, E_FE};
    foreach (seq[i]) ercnt_framer_model_i.strobe(seq[i], 1);
    rd_chk(OFS_SEF, 8'h02);
    rd_chk(OFS_SEF, 8'h00);
    rd16(OFS_FAE_HIGH, 16'h0007);
  endtask
  initial begin
    err_count = 0;
    checks_done = 0;
    nrst = 1'b0;
    rd = '0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_lcv();
    t_fae_crc();
    t_sef();
    final_report();
  end
  // a hang cannot pass: the limit counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
